// File: cbt_bit_sampler.sv
// Bit sampler: single sample or majority of the last three quanta.
// Assumes rx_i is synchronous and sample_en_i coincides with a tq enable.
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_sampler (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tq_en_i,
  input wire logic sample_en_i,
  input wire logic triple_i,
  input wire logic rx_i,
  output logic rx_bit_o,
  output logic rx_bit_valid_o
);
  import cbt_pkg::*;

  typedef struct packed {
    logic [1:0] hist;
    logic bitv;
    logic valid;
  } cbt_smp_st_t;

  cbt_smp_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.valid = 1'b0;
    if (tq_en_i) begin
      s_d.hist = {s_q.hist[0], rx_i};
    end
    if (sample_en_i) begin
      s_d.valid = 1'b1;
      if (triple_i) begin
        s_d.bitv = (s_q.hist[1] & s_q.hist[0]) | (s_q.hist[1] & rx_i)
          | (s_q.hist[0] & rx_i);
      end else begin
        s_d.bitv = rx_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_bit_o = s_q.bitv;
  assign rx_bit_valid_o = s_q.valid;

  property p_single;
    @(posedge clk_i) disable iff (rst_i)
    sample_en_i && !triple_i |=> rx_bit_valid_o && rx_bit_o == $past(rx_i);
  endproperty
  a_single: assert property (p_single)
    else $error("single sample does not match the line");

  property p_triple;
    @(posedge clk_i) disable iff (rst_i)
    sample_en_i && triple_i |=> rx_bit_o ==
      (($past(s_q.hist[1]) & $past(s_q.hist[0]))
      | ($past(s_q.hist[1]) & $past(rx_i))
      | ($past(s_q.hist[0]) & $past(rx_i)));
  endproperty
  a_triple: assert property (p_triple)
    else $error("majority of three samples is wrong");
endmodule
`default_nettype wire

// File: cbt_bit_timing.sv
// Top of the CAN bit-timing block: Wishbone registers, bit phase machine.
// Assumes synchronous inputs, one clock and a master that keeps
// cyc/stb until ack.
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module cbt_bit_timing (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cbt_pkg::cbt_wb_req_t wb_i,
  output var cbt_pkg::cbt_wb_rsp_t wb_o,
  input wire logic osc_en_i,
  input wire logic rx_i,
  input wire logic [3:0] flag_set_i,
  input wire logic [3:0] flag_cond_i,
  input wire logic [1:0] receiver_state_i,
  input wire logic [1:0] transmitter_state_i,
  output logic tq_en_o,
  output logic bit_start_o,
  output logic sample_point_o,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic init_mode_o,
  output logic irq_o
);
  import cbt_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] pre;
    logic [7:0] seg;
    logic [3:0] flg;
    logic [3:0] rier;
    logic [1:0] ev;
    logic [1:0] evm;
    logic rq;
    logic ak;
    logic clksel;
    cbt_phase_t ph;
    logic [4:0] cnt;
    logic [4:0] len1;
    logic [3:0] len2;
    logic synced;
    logic rx_prev;
    logic bstart;
    logic spt;
    logic [5:0] hq;
  } cbt_core_st_t;

  localparam cbt_core_st_t CORE_RST = '{
    pre: CBT_PRE_RST,
    seg: CBT_SEG_RST,
    flg: CBT_FLG_RST,
    rier: CBT_RIER_RST,
    evm: CBT_EVM_RST,
    rq: CBT_CTL_RST[CBT_CTL_RQ_BIT],
    clksel: CBT_CTL_RST[CBT_CTL_CLK_BIT],
    ph: CBT_SYNC,
    rx_prev: 1'b1,
    default: '0
  };

  cbt_core_st_t s_q, s_d;
  logic tq_en, can_en, in_init, req, wr, rd, edge_now, spt, rx_valid;
  logic [5:0] idx;
  logic [7:0] wd, rv;
  logic [3:0] clr, keep_v;
  logic [4:0] e, ext, jw, r, seg1_q, seg2_q;

  assign in_init = s_q.rq & s_q.ak;
  assign can_en = s_q.clksel | osc_en_i;
  assign req = wb_i.cyc & wb_i.stb & ~s_q.ack;
  assign wr = req & wb_i.we & wb_i.sel[0];
  assign rd = req & ~wb_i.we;
  assign idx = wb_i.adr[CBT_ADR_LSB +: 6];
  assign wd = wb_i.dat[7:0];
  assign jw = 5'(s_q.pre[CBT_JW_LSB +: 2]) + 5'h01;
  assign seg1_q = 5'(s_q.seg[CBT_SEG1_LSB +: 4]) + 5'h01;
  assign seg2_q = 5'(s_q.seg[CBT_SEG2_LSB +: 3]) + 5'h01;
  assign edge_now = tq_en & s_q.rx_prev & ~rx_i;
  assign keep_v = s_q.flg & ~clr & {4{~in_init}};

  cbt_tq_prescaler #(
    .DIV_W(6)
  ) u_prescaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .can_en_i(can_en),
    .hold_i(in_init),
    .div_i(s_q.pre[CBT_PRE_LSB +: 6]),
    .tq_en_o(tq_en)
  );

  cbt_bit_sampler u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tq_en_i(tq_en),
    .sample_en_i(spt),
    .triple_i(s_q.seg[CBT_TRIPLE_BIT]),
    .rx_i(rx_i),
    .rx_bit_o(rx_bit_o),
    .rx_bit_valid_o(rx_valid)
  );

  // Read view of the register map; the state fields mirror live inputs.
  always_comb begin
    rv = 8'h00;
    case (idx)
      CBT_IDX_CTL: begin
        rv[CBT_CTL_RQ_BIT] = s_q.rq;
        rv[CBT_CTL_AK_BIT] = s_q.ak;
        rv[CBT_CTL_CLK_BIT] = s_q.clksel;
      end
      CBT_IDX_PRE: rv = s_q.pre;
      CBT_IDX_SEG: rv = s_q.seg;
      CBT_IDX_FLG: begin
        rv[CBT_WAKE_BIT] = s_q.flg[3];
        rv[CBT_STAT_BIT] = s_q.flg[2];
        rv[CBT_RECEIVER_STATE_LSB +: 2] = receiver_state_i;
        rv[CBT_TRANSMITTER_STATE_LSB +: 2] = transmitter_state_i;
        rv[CBT_OVR_BIT] = s_q.flg[1];
        rv[CBT_RXF_BIT] = s_q.flg[0];
      end
      CBT_IDX_RIER: begin
        rv[CBT_WAKE_BIT] = s_q.rier[3];
        rv[CBT_STAT_BIT] = s_q.rier[2];
        rv[CBT_OVR_BIT] = s_q.rier[1];
        rv[CBT_RXF_BIT] = s_q.rier[0];
      end
      CBT_IDX_EV: rv = {6'h00, s_q.ev};
      CBT_IDX_EVM: rv = {6'h00, s_q.evm};
      default: rv = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.bstart = 1'b0;
    s_d.spt = 1'b0;
    s_d.ak = s_q.rq;
    clr = 4'h0;
    e = 5'h00;
    ext = 5'h00;
    r = 5'h00;
    spt = 1'b0;
    if (req) begin
      s_d.rdat = {24'h000000, rv};
    end
    if (rd && idx == CBT_IDX_EV) begin
      s_d.ev = 2'h0;
    end
    if (wr) begin
      case (idx)
        CBT_IDX_CTL: begin
          s_d.rq = wd[CBT_CTL_RQ_BIT];
          if (in_init) begin
            s_d.clksel = wd[CBT_CTL_CLK_BIT];
          end
        end
        CBT_IDX_PRE: begin
          if (in_init) begin
            s_d.pre = wd;
          end
        end
        CBT_IDX_SEG: begin
          if (in_init) begin
            s_d.seg = wd;
          end
        end
        CBT_IDX_FLG: begin
          // A one clears only once the flag's cause has gone away.
          if (!in_init) begin
            clr = {wd[CBT_WAKE_BIT], wd[CBT_STAT_BIT], wd[CBT_OVR_BIT],
              wd[CBT_RXF_BIT]} & ~flag_cond_i;
          end
        end
        CBT_IDX_RIER: begin
          s_d.rier = {wd[CBT_WAKE_BIT], wd[CBT_STAT_BIT], wd[CBT_OVR_BIT],
            wd[CBT_RXF_BIT]};
        end
        CBT_IDX_EVM: s_d.evm = wd[1:0];
        default: ;
      endcase
    end
    if (in_init) begin
      s_d.flg = CBT_FLG_RST;
    end else begin
      s_d.flg = (s_q.flg & ~clr) | flag_set_i;
    end
    if (rx_valid) begin
      s_d.ev[0] = 1'b1;
    end
    // The phase machine is held in CBT_SYNC with its counters cleared while the timing is being configured.
    if (in_init) begin
      s_d.ph = CBT_SYNC;
      s_d.cnt = 5'h00;
      s_d.synced = 1'b0;
      s_d.rx_prev = 1'b1;
      s_d.hq = 6'h00;
    end else if (tq_en) begin
      s_d.rx_prev = rx_i;
      e = s_q.cnt + 5'h01;
      case (s_q.ph)
        CBT_SYNC: begin
          s_d.ph = CBT_SEG1;
          s_d.cnt = 5'h00;
          s_d.len1 = seg1_q;
          s_d.len2 = seg2_q[3:0];
          s_d.synced = 1'b0;
        end
        CBT_SEG1: begin
          s_d.cnt = e;
          if (edge_now && !s_q.synced) begin
            ext = (e < jw) ? e : jw;
            s_d.len1 = s_q.len1 + ext;
            s_d.synced = 1'b1;
            s_d.ev[1] = 1'b1;
          end
          if (e >= s_d.len1) begin
            spt = 1'b1;
            s_d.spt = 1'b1;
            s_d.ph = CBT_SEG2;
            s_d.cnt = 5'h00;
          end
        end
        CBT_SEG2: begin
          s_d.cnt = e;
          r = 5'(s_q.len2) - e;
          if (edge_now && !s_q.synced) begin
            s_d.ev[1] = 1'b1;
            // An early edge within the jump width starts the next bit.
            if (r <= jw) begin
              s_d.ph = CBT_SEG1;
              s_d.cnt = 5'h00;
              s_d.len1 = seg1_q;
              s_d.len2 = seg2_q[3:0];
              s_d.synced = 1'b0;
              s_d.bstart = 1'b1;
            end else begin
              s_d.len2 = s_q.len2 - jw[3:0];
              s_d.synced = 1'b1;
            end
          end else if (e >= 5'(s_q.len2)) begin
            s_d.ph = CBT_SYNC;
            s_d.cnt = 5'h00;
            s_d.bstart = 1'b1;
          end
        end
        default: begin
          s_d.ph = CBT_SYNC;
          s_d.cnt = 5'h00;
        end
      endcase
      // An early start in segment two counts the edge quantum as sync.
      s_d.hq = !s_d.bstart ? s_q.hq + 6'h01
        : (s_d.ph == CBT_SYNC) ? 6'h00 : 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_o.ack = s_q.ack;
  assign wb_o.dat = s_q.rdat;
  assign tq_en_o = tq_en;
  assign bit_start_o = s_q.bstart;
  assign sample_point_o = s_q.spt;
  assign rx_bit_valid_o = rx_valid;
  assign init_mode_o = in_init;
  assign irq_o = |(s_q.ev & s_q.evm) | |(s_q.flg & s_q.rier);

  property p_btr_locked;
    @(posedge clk_i) disable iff (rst_i)
    wr && !in_init && (idx == CBT_IDX_PRE || idx == CBT_IDX_SEG)
      |=> s_q.pre == $past(s_q.pre) && s_q.seg == $past(s_q.seg);
  endproperty
  a_btr_locked: assert property (p_btr_locked)
    else $error("timing register changed outside init mode");

  property p_jw_limit;
    @(posedge clk_i) disable iff (rst_i)
    s_q.ph == CBT_SEG1 |-> s_q.len1 <= seg1_q + jw;
  endproperty
  a_jw_limit: assert property (p_jw_limit)
    else $error("segment one stretched beyond the jump width");

  property p_sample_pos;
    @(posedge clk_i) disable iff (rst_i)
    spt && !s_q.synced && !edge_now |-> s_q.hq == 6'(seg1_q)
      ##1 sample_point_o;
  endproperty
  a_sample_pos: assert property (p_sample_pos)
    else $error("sample point not at end of segment one");

  property p_bit_len;
    @(posedge clk_i) disable iff (rst_i)
    !in_init && tq_en && s_q.ph == CBT_SEG2 && !s_q.synced && !edge_now
      && s_q.cnt + 5'h01 >= 5'(s_q.len2)
      |-> s_q.hq == 6'(seg1_q) + 6'(seg2_q) ##1 bit_start_o;
  endproperty
  a_bit_len: assert property (p_bit_len)
    else $error("bit time differs from sync plus both segments");

  property p_flag_keep;
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ($past(keep_v) & ~s_q.flg) == 4'h0;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("receiver flag dropped without a valid clear");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    !in_init && |flag_set_i
      |=> (s_q.flg & $past(flag_set_i)) == $past(flag_set_i);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("receiver flag event lost");

  property p_init_flags;
    @(posedge clk_i) disable iff (rst_i)
    in_init |=> s_q.flg == CBT_FLG_RST;
  endproperty
  a_init_flags: assert property (p_init_flags)
    else $error("receiver flags not held during init mode");
endmodule
`default_nettype wire

// File: cbt_bus_node.sv
// Model of another CAN node that drives the receive line of the block.
// Assumes bit_start_i marks each bit; the line idles recessive (high).
// A non-zero lag_i delays each new bit by that many clocks after the bit
// start, so that its edges fall after the sync quantum.
`timescale 1ns/10ps
`default_nettype none
module cbt_bus_node (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bit_start_i,
  input wire logic send_i,
  input wire logic [7:0] pattern_i,
  input wire logic [3:0] lag_i,
  output logic rx_o
);
  logic [2:0] idx_q;
  logic [3:0] wait_q;

  // A released bus floats back to recessive, never to the last bit sent.
  always_ff @(posedge clk_i) begin
    if (rst_i || !send_i) begin
      idx_q <= 3'h0;
      rx_o <= 1'b1;
      wait_q <= 4'h0;
    end else if (bit_start_i && lag_i == 4'h0) begin
      rx_o <= pattern_i[idx_q];
      idx_q <= idx_q + 3'h1;
    end else if (bit_start_i) begin
      wait_q <= lag_i;
    end else if (wait_q == 4'h1) begin
      rx_o <= pattern_i[idx_q];
      idx_q <= idx_q + 3'h1;
      wait_q <= 4'h0;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: cbt_pkg.sv
// Package for the CAN bit-timing block: register map, fields, resets, types.
// Assumes a classic Wishbone slave with 32-bit data on one 20 MHz clock.
package cbt_pkg;
  localparam int unsigned CBT_ADR_LSB = 2;
  localparam logic [5:0] CBT_IDX_CTL = 6'h00;
  localparam logic [5:0] CBT_IDX_PRE = 6'h02;
  localparam logic [5:0] CBT_IDX_SEG = 6'h03;
  localparam logic [5:0] CBT_IDX_FLG = 6'h04;
  localparam logic [5:0] CBT_IDX_RIER = 6'h05;
  localparam logic [5:0] CBT_IDX_EV = 6'h06;
  localparam logic [5:0] CBT_IDX_EVM = 6'h07;
  localparam int unsigned CBT_CTL_RQ_BIT = 0;
  localparam int unsigned CBT_CTL_AK_BIT = 1;
  localparam int unsigned CBT_CTL_CLK_BIT = 2;
  localparam int unsigned CBT_JW_LSB = 6;
  localparam int unsigned CBT_PRE_LSB = 0;
  localparam int unsigned CBT_TRIPLE_BIT = 7;
  localparam int unsigned CBT_SEG2_LSB = 4;
  localparam int unsigned CBT_SEG1_LSB = 0;
  localparam int unsigned CBT_WAKE_BIT = 7;
  localparam int unsigned CBT_STAT_BIT = 6;
  localparam int unsigned CBT_RECEIVER_STATE_LSB = 4;
  localparam int unsigned CBT_TRANSMITTER_STATE_LSB = 2;
  localparam int unsigned CBT_OVR_BIT = 1;
  localparam int unsigned CBT_RXF_BIT = 0;
  localparam logic [7:0] CBT_CTL_RST = 8'h01;
  localparam logic [7:0] CBT_PRE_RST = 8'h00;
  localparam logic [7:0] CBT_SEG_RST = 8'h00;
  localparam logic [3:0] CBT_FLG_RST = 4'h0;
  localparam logic [3:0] CBT_RIER_RST = 4'h0;
  localparam logic [1:0] CBT_EVM_RST = 2'h0;

  typedef enum logic [1:0] {CBT_SYNC, CBT_SEG1, CBT_SEG2} cbt_phase_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } cbt_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } cbt_wb_rsp_t;
endpackage

// File: cbt_tq_prescaler.sv
// Time-quantum divider: one tq enable per (code + 1) CAN clock enables.
// Assumes the CAN clock arrives as a one-cycle enable on clk_i.
`timescale 1ns/10ps
`default_nettype none
module cbt_tq_prescaler #(
  parameter int unsigned DIV_W = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic can_en_i,
  input wire logic hold_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tq_en_o
);
  import cbt_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tq;
  } cbt_pre_st_t;

  cbt_pre_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tq = 1'b0;
    if (hold_i) begin
      s_d.cnt = '0;
    end else if (can_en_i) begin
      // Greater-or-equal keeps the count bounded if the divisor shrinks.
      if (s_q.cnt >= div_i) begin
        s_d.cnt = '0;
        s_d.tq = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tq_en_o = s_q.tq;

  property p_tq_fire;
    @(posedge clk_i) disable iff (rst_i)
    !hold_i && can_en_i && s_q.cnt == div_i |=> tq_en_o;
  endproperty
  a_tq_fire: assert property (p_tq_fire)
    else $error("quantum enable missing at divider end");

  property p_tq_cause;
    @(posedge clk_i) disable iff (rst_i)
    tq_en_o |-> $past(can_en_i) && !$past(hold_i)
      && $past(s_q.cnt) >= $past(div_i);
  endproperty
  a_tq_cause: assert property (p_tq_cause)
    else $error("quantum enable without full division");
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the CAN bit-timing block.
// Assumes the block's own assertions run inside the design files.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cbt_pkg::*;
  logic clk_i, rst_i, osc_en_i, rx_i, send_q;
  cbt_wb_req_t wb_i;
  cbt_wb_rsp_t wb_o;
  logic [3:0] flag_set_i, flag_cond_i;
  logic [1:0] osc_q;
  logic [3:0] lag_q;
  logic tq_en_o, bit_start_o, sample_point_o, rx_bit_o, rx_bit_valid_o;
  logic init_mode_o, irq_o;
  logic [7:0] q;
  int failures, checks_done, n;

  cbt_bit_timing cbt_bit_timing_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_i(wb_i), .wb_o(wb_o), .osc_en_i(osc_en_i), .rx_i(rx_i),
    .flag_set_i(flag_set_i), .flag_cond_i(flag_cond_i),
    .receiver_state_i(2'h2), .transmitter_state_i(2'h1),
    .tq_en_o(tq_en_o), .bit_start_o(bit_start_o),
    .sample_point_o(sample_point_o), .rx_bit_o(rx_bit_o),
    .rx_bit_valid_o(rx_bit_valid_o), .init_mode_o(init_mode_o),
    .irq_o(irq_o));
  cbt_bus_node cbt_bus_node_i (.clk_i(clk_i), .rst_i(rst_i),
    .bit_start_i(bit_start_o), .send_i(send_q), .pattern_i(8'hb2),
    .lag_i(lag_q), .rx_o(rx_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // The oscillator enable pulses every third cycle to tell it from clk_i.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_q <= 2'h0;
      osc_en_i <= 1'b0;
    end else begin
      osc_q <= (osc_q == 2'h2) ? 2'h0 : osc_q + 2'h1;
      osc_en_i <= (osc_q == 2'h1);
    end
  end

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  // Only the watchdog ends a wait for the acknowledge.
  task acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf,
              dat: {24'h0, d}};
    do @(posedge clk_i); while (wb_o.ack !== 1'b1);
    q = wb_o.dat[7:0];
    wb_i <= '0;
  endtask

  task rdc(input string s, input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(s, {24'h0, e}, {24'h0, q});
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: pick = tq_en_o;
      1: pick = bit_start_o;
      2: pick = sample_point_o;
      default: pick = rx_bit_valid_o;
    endcase
  endfunction

  task waitp(input int k);
    int c;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (pick(k) !== 1'b1 && c < 400);
    if (pick(k) !== 1'b1) failures++;
  endtask

  task gap(input int a, input int b);
    waitp(a);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pick(b) !== 1'b1 && n < 400);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done();
  end

  initial begin
    failures = 0;
    checks_done = 0;
    rst_i = 1'b1;
    wb_i = '0;
    lag_q = 4'h0;
    send_q = 1'b0;
    flag_set_i = 4'h0;
    flag_cond_i = 4'h0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("ctl", 8'h00, 8'h03);
    rdc("prescale", 8'h08, 8'h00);
    rdc("segments", 8'h0c, 8'h00);
    rdc("unmapped", 8'h20, 8'h00);
    acc(1'b1, 8'h08, 8'h41);
    acc(1'b1, 8'h0c, 8'h13);
    acc(1'b1, 8'h00, 8'h05);
    rdc("prescale", 8'h08, 8'h41);
    rdc("segments", 8'h0c, 8'h13);
    @(posedge clk_i);
    flag_set_i <= 4'hf;
    @(posedge clk_i);
    flag_set_i <= 4'h0;
    rdc("flags in init", 8'h10, 8'h24);
    acc(1'b1, 8'h10, 8'h00);
    acc(1'b1, 8'h00, 8'h04);
    rdc("ctl", 8'h00, 8'h04);
    chk("init_mode", 32'h0, {31'h0, init_mode_o});
    acc(1'b1, 8'h08, 8'h00);
    rdc("locked prescale", 8'h08, 8'h41);
    gap(0, 0);
    chk("tq gap", 32'd2, 32'(n));
    gap(1, 1);
    chk("bit gap", 32'd14, 32'(n));
    gap(1, 2);
    chk("sample gap", 32'd10, 32'(n));
    @(posedge clk_i);
    flag_set_i <= 4'h3;
    flag_cond_i <= 4'h3;
    @(posedge clk_i);
    flag_set_i <= 4'h0;
    rdc("flags set", 8'h10, 8'h27);
    acc(1'b1, 8'h10, 8'hff);
    rdc("flags cause on", 8'h10, 8'h27);
    acc(1'b1, 8'h14, 8'h02);
    chk("irq flag", 32'h1, {31'h0, irq_o});
    flag_cond_i <= 4'h0;
    acc(1'b1, 8'h10, 8'h00);
    rdc("flags write 0", 8'h10, 8'h27);
    acc(1'b1, 8'h10, 8'h02);
    rdc("flags clear", 8'h10, 8'h25);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    acc(1'b1, 8'h10, 8'h01);
    acc(1'b1, 8'h1c, 8'h01);
    @(posedge clk_i);
    chk("irq event", 32'h1, {31'h0, irq_o});
    acc(1'b0, 8'h18, 8'h00);
    chk("event sampled", 32'h1, {31'h0, q[0]});
    acc(1'b1, 8'h1c, 8'h00);
    @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    for (int s = 0; s < 3; s++) begin
      acc(1'b1, 8'h00, 8'h05);
      acc(1'b1, 8'h0c, (s == 1) ? 8'h93 : 8'h13);
      acc(1'b1, 8'h00, 8'h04);
      @(posedge clk_i);
      send_q <= 1'b1;
      lag_q <= (s == 2) ? 4'h2 : 4'h0;
      for (int b = 0; b < 8; b++) begin
        waitp(3);
        chk("rx bit", {31'h0, rx_i}, {31'h0, rx_bit_o});
      end
      @(posedge clk_i);
      send_q <= 1'b0;
      rdc("resync event", 8'h18, (s == 2) ? 8'h03 : 8'h01);
    end
    acc(1'b1, 8'h00, 8'h05);
    acc(1'b1, 8'h00, 8'h01);
    acc(1'b1, 8'h00, 8'h00);
    gap(0, 0);
    chk("osc tq gap", 32'd6, 32'(n));
    test_done();
  end
endmodule
`default_nettype wire
